// ### logic/adc_readout.sv
/*
 * Digital side of an eight-channel 16-bit converter in internal clock mode:
 * control byte capture on the serial clock, self-timed conversion, busy,
 * result holding register and serial shift-out, power modes.
 * Assumes the host owns the serial clock and chip select; the analog value
 * arrives as a quasi-static two's complement word on analog_level.
 */
// How it works
// - conversion is timed by the system clock, no serial edges needed.
// - result may be read whenever the host likes, at serial rates slow enough for the system clock to sample.
// - busy falls when a conversion starts and rises once it completes.
// - busy stays low at most eight microseconds per conversion.
// - each result sits in a holding register for later shift-out.
// - chip select low at completion: MSB on next falling edge, then the rest.
// - chip select high at completion: data pin stays released until select.
// - a started conversion finishes even if chip select rises.
// - busy is always driven, never released.
// - results are two's complement, 7FFF down to 8000.
// - full power, auto power-down and shutdown modes are supported.
// - shutdown pin low forces power-down at once, aborting conversion.
// - first conversion out of auto power-down is valid without delay.
// - power-mode bits high then low select internal clock mode.
// - serial input is ignored until a high start bit opens a byte.
`timescale 1ns/1ps
`include "adc_readout_consts.svh"
module adc_readout
    import adc_readout_pkg::*;
(
    input  wire logic                 clk,                // system clock, 100 MHz
    input  wire logic                 rst,                // async reset, active high
    input  wire logic                 serial_shift_clock, // host serial clock
    input  wire logic                 cs_n,               // chip select, active low
    input  wire logic                 sdi,                // serial data in
    input  wire logic                 power_off_n,        // shutdown pin, active low
    input  wire logic [`RESULT_W-1:0] analog_level,       // sampled input, two's complement
    output logic                      busy,               // high when idle
    output logic                      sdo,                // serial data out
    output logic                      sdo_oe_n,           // low while sdo is driven
    output power_state_t              power_state,        // present power mode
    output mux_cfg_t                  mux_cfg             // channel selection of this conversion
);

    // ----------------------------------------------------------------------
    // link side: control byte capture on serial clock rising edges
    // ----------------------------------------------------------------------
    // deselect clears the byte hunt; the toggle and byte are reset by rst only
    wire        link_clr = rst | cs_n;
    logic       hunt_ff;
    logic [2:0] cnt_in_ff;
    logic [5:0] shreg_ff;
    logic [`CTRL_W-1:0] byte_ff;
    logic       byte_tog_ff;
    wire        byte_done_w = hunt_ff && (cnt_in_ff == 3'h6);

    always_ff @(posedge serial_shift_clock or posedge link_clr) begin
        if (link_clr) begin
            hunt_ff   <= 1'b0;
            cnt_in_ff <= 3'h0;
            shreg_ff  <= 6'h00;
        end else if (!hunt_ff) begin
            hunt_ff   <= sdi;
            cnt_in_ff <= 3'h0;
        end else begin
            shreg_ff  <= {shreg_ff[4:0], sdi};
            cnt_in_ff <= cnt_in_ff + 3'h1;
            if (byte_done_w) hunt_ff <= 1'b0;
        end
    end

    always_ff @(posedge serial_shift_clock or posedge rst) begin
        if (rst) begin
            byte_ff     <= `CTRL_RST;
            byte_tog_ff <= 1'b0;
        end else if (byte_done_w) begin
            byte_ff     <= {1'b1, shreg_ff, sdi};
            byte_tog_ff <= ~byte_tog_ff;
        end
    end

    // ----------------------------------------------------------------------
    // crossings into the system clock
    // ----------------------------------------------------------------------
    // a change counts once stages two and three agree; byte_ff is stable for
    // eight serial edges after its toggle, far longer than the sync delay
    wire  [`SYNC_W-1:0] sync_in = {analog_level, byte_tog_ff, power_off_n, cs_n, serial_shift_clock};
    logic [`SYNC_W-1:0] s1_ff;
    logic [`SYNC_W-1:0] s2_ff;
    logic [`SYNC_W-1:0] s3_ff;
    logic [`SYNC_W-1:0] stable_ff;
    wire  [`SYNC_W-1:0] agree_w    = ~(s2_ff ^ s3_ff);
    wire  [`SYNC_W-1:0] nxt_stable = (agree_w & s3_ff) | (~agree_w & stable_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_ff     <= `SYNC_RST;
            s2_ff     <= `SYNC_RST;
            s3_ff     <= `SYNC_RST;
            stable_ff <= `SYNC_RST;
        end else begin
            s1_ff     <= sync_in;
            s2_ff     <= s1_ff;
            s3_ff     <= s2_ff;
            stable_ff <= nxt_stable;
        end
    end

    wire                 sclk_fall_w = stable_ff[0] && !nxt_stable[0];
    wire                 cs_hi_w     = nxt_stable[1];
    wire                 cs_fall_w   = stable_ff[1] && !nxt_stable[1];
    wire                 pwr_on_w    = nxt_stable[2];
    wire [`RESULT_W-1:0] level_w     = nxt_stable[`SYNC_W-1:4];

    // ----------------------------------------------------------------------
    // control byte decode and clock mode
    // ----------------------------------------------------------------------
    logic       tog_seen_ff;
    logic       int_clk_mode_ff;
    logic       auto_pd_ff;
    ctrl_byte_t ctrl_w;
    wire        new_byte_w = (nxt_stable[3] != tog_seen_ff);
    wire [1:0]  pd_w       = {ctrl_w.power_mode_hi_bit, ctrl_w.power_mode_lo_bit};
    wire        sel_int_w  = (pd_w == `PD_INTERNAL_CLK);
    wire        sel_ext_w  = (pd_w == `PD_EXTERNAL_CLK);
    wire        sel_apd_w  = (pd_w == `PD_AUTO_DOWN);
    wire        int_next_w = sel_int_w || (sel_apd_w && int_clk_mode_ff);
    conv_state_t conv_state_ff;
    wire        start_conv_w = new_byte_w && pwr_on_w && int_next_w && (conv_state_ff == CV_IDLE);

    assign ctrl_w = ctrl_byte_t'(byte_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_seen_ff     <= 1'b0;
            int_clk_mode_ff <= 1'b0;
            auto_pd_ff      <= 1'b0;
        end else if (new_byte_w) begin
            tog_seen_ff <= nxt_stable[3];
            if (sel_int_w) int_clk_mode_ff <= 1'b1;
            if (sel_ext_w) int_clk_mode_ff <= 1'b0;
            auto_pd_ff  <= sel_apd_w;
        end
    end

    // ----------------------------------------------------------------------
    // self-timed successive approximation
    // ----------------------------------------------------------------------
    // the search runs on offset binary; flipping the sign bit at both ends
    // yields two's complement codes without a subtractor
    logic [`RESULT_W-1:0] sampled_ff;
    logic [`RESULT_W-1:0] sar_ff;
    logic [3:0]           bit_idx_ff;
    logic [9:0]           step_ff;
    logic                 busy_ff;
    logic                 fifo_in_ready;
    wire                  step_end_w = (step_ff == 10'(`SAR_STEP_CYC - 1));
    wire [`RESULT_W-1:0]  target_w   = sampled_ff ^ `SIGN_FLIP;
    wire [`RESULT_W-1:0]  trial_w    = sar_ff | (`RESULT_W'(1) << bit_idx_ff);
    wire [`RESULT_W-1:0]  code_w     = sar_ff ^ `SIGN_FLIP;
    wire                  push_w     = (conv_state_ff == CV_PUSH) && fifo_in_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_state_ff <= CV_IDLE;
            busy_ff       <= 1'b1;
            sampled_ff    <= `RESULT_RST;
            sar_ff        <= `RESULT_RST;
            bit_idx_ff    <= 4'hF;
            step_ff       <= 10'h000;
            mux_cfg       <= '0;
        end else if (!pwr_on_w) begin
            conv_state_ff <= CV_IDLE;
            busy_ff       <= 1'b1;
        end else begin
            case (conv_state_ff)
                CV_IDLE: begin
                    if (start_conv_w) begin
                        conv_state_ff <= CV_SAR;
                        busy_ff       <= 1'b0;
                        sampled_ff    <= level_w;
                        sar_ff        <= `RESULT_RST;
                        bit_idx_ff    <= 4'hF;
                        step_ff       <= 10'h000;
                        mux_cfg       <= '{chan: ctrl_w.chan, single_ended: ctrl_w.single_ended};
                    end
                end
                CV_SAR: begin
                    // cs is not looked at here, so deselect cannot abort
                    step_ff <= step_end_w ? 10'h000 : step_ff + 10'h001;
                    if (step_end_w) begin
                        if (trial_w <= target_w) sar_ff <= trial_w;
                        bit_idx_ff <= bit_idx_ff - 4'h1;
                        if (bit_idx_ff == 4'h0) conv_state_ff <= CV_PUSH;
                    end
                end
                CV_PUSH: begin
                    if (fifo_in_ready) begin
                        conv_state_ff <= CV_IDLE;
                        busy_ff       <= 1'b1;
                    end
                end
                default: conv_state_ff <= CV_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // result buffer between converter and shift-out
    // ----------------------------------------------------------------------
    logic                 fifo_out_valid;
    logic [`RESULT_W-1:0] fifo_out_data;
    logic                 shift_active_ff;
    // a finished result always replaces the held word, even in mid-shift,
    // so the MSB of the new word follows busy rising with select low
    wire                  pop_w = fifo_out_valid;

    word_fifo #(.WIDTH(`RESULT_W), .DEPTH(`FIFO_DEPTH)) u_result_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (conv_state_ff == CV_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (code_w),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    // ----------------------------------------------------------------------
    // holding register and serial shift-out
    // ----------------------------------------------------------------------
    logic [`RESULT_W-1:0] hold_ff;
    logic                 have_result_ff;
    logic [3:0]           out_idx_ff;
    wire                  cur_bit_w = hold_ff[out_idx_ff];
    wire                  arm_w     = (pop_w && !cs_hi_w) || (cs_fall_w && have_result_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_ff        <= `RESULT_RST;
            have_result_ff <= 1'b0;
        end else if (pop_w) begin
            hold_ff        <= fifo_out_data;
            have_result_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_active_ff <= 1'b0;
            out_idx_ff      <= 4'hF;
            sdo             <= 1'b0;
            sdo_oe_n        <= 1'b1;
        end else begin
            sdo_oe_n <= cs_hi_w;
            if (cs_hi_w) begin
                shift_active_ff <= 1'b0;
                sdo             <= 1'b0;
            end else if (arm_w) begin
                shift_active_ff <= 1'b1;
                out_idx_ff      <= 4'hF;
                sdo             <= 1'b0;
            end else if (shift_active_ff && sclk_fall_w) begin
                sdo        <= cur_bit_w;
                out_idx_ff <= out_idx_ff - 4'h1;
                if (out_idx_ff == 4'h0) shift_active_ff <= 1'b0;
            end else if (!shift_active_ff && sclk_fall_w) begin
                sdo <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // busy and power state outputs
    // ----------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_state <= PWR_FULL;
        end else if (!pwr_on_w) begin
            power_state <= PWR_SHUTDOWN;
        end else if (auto_pd_ff && (conv_state_ff == CV_IDLE) && !start_conv_w) begin
            power_state <= PWR_AUTO_DOWN;
        end else begin
            power_state <= PWR_FULL;
        end
    end

    assign busy = busy_ff;

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    logic [10:0] low_cnt_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) low_cnt_ff <= 11'h000;
        else if (busy_ff) low_cnt_ff <= 11'h000;
        else low_cnt_ff <= low_cnt_ff + 11'h001;
    end

    property p_busy_falls_on_start;
        @(posedge clk) disable iff (rst) start_conv_w |=> !busy && (conv_state_ff == CV_SAR);
    endproperty
    a_busy_falls_on_start: assert property (p_busy_falls_on_start) else $error("busy did not fall at start");

    property p_busy_rises_on_done;
        @(posedge clk) disable iff (rst) push_w && pwr_on_w |=> busy ##1 (busy || $past(start_conv_w));
    endproperty
    a_busy_rises_on_done: assert property (p_busy_rises_on_done) else $error("busy did not rise at completion");

    property p_conv_time;
        @(posedge clk) disable iff (rst) low_cnt_ff < 11'(`CONV_MAX_CYC);
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion ran too long");

    property p_code;
        @(posedge clk) disable iff (rst) push_w |-> (code_w == sampled_ff);
    endproperty
    a_code: assert property (p_code) else $error("result code does not match sampled level");

    property p_hold_stable;
        @(posedge clk) disable iff (rst) !pop_w |=> $stable(hold_ff);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("holding register changed without new result");

    property p_bit_order;
        @(posedge clk) disable iff (rst)
            shift_active_ff && sclk_fall_w && !cs_hi_w && !arm_w |=> sdo == $past(cur_bit_w);
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("wrong bit on serial output");

    property p_released;
        @(posedge clk) disable iff (rst) cs_hi_w |=> sdo_oe_n ##1 (sdo_oe_n || !cs_hi_w);
    endproperty
    a_released: assert property (p_released) else $error("data pin driven while deselected");

    property p_no_abort;
        @(posedge clk) disable iff (rst) (conv_state_ff == CV_SAR) && pwr_on_w |=> (conv_state_ff != CV_IDLE);
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("conversion abandoned");

    property p_shutdown;
        @(posedge clk) disable iff (rst) !pwr_on_w |=> (power_state == PWR_SHUTDOWN) && busy;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not immediate");

    property p_wake;
        @(posedge clk) disable iff (rst) start_conv_w |=> (power_state == PWR_FULL);
    endproperty
    a_wake: assert property (p_wake) else $error("no full power at conversion start");

endmodule // adc_readout

// ### logic/adc_readout_consts.svh
/*
 * Constants of the internally clocked converter readout: field positions of
 * the control byte, power-mode encodings, reset values and timing counts.
 * Assumes a 100 MHz system clock; included by bare name where needed.
 */
`ifndef ADC_READOUT_CONSTS_SVH
`define ADC_READOUT_CONSTS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define CONV_MAX_NS         8000
`define CONV_MAX_CYC        (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define SAMPLE_WINDOW_NS    1700
`define RESULT_W            16
`define SAR_STEP_CYC        (`CONV_MAX_CYC / (`RESULT_W + 1))

// ----------------------------------------------------------------------
// control byte layout and power-mode codes
// ----------------------------------------------------------------------
`define CB_START_BIT        7
`define CB_CHAN_HI          6
`define CB_CHAN_LO          4
`define CB_SGL_BIT          2
`define CB_PD_HI            1
`define CB_PD_LO            0
`define CTRL_W              8
`define PD_AUTO_DOWN        2'h0
`define PD_INTERNAL_CLK     2'h2
`define PD_EXTERNAL_CLK     2'h3

// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define RESULT_RST          16'h0000
`define CTRL_RST            8'h00
`define SIGN_FLIP           16'h8000
`define SYNC_W              20
`define SYNC_RST            20'h00006
`define FIFO_DEPTH          4

`endif

// ### logic/adc_readout_pkg.sv
/*
 * Types shared by the converter readout: power states, conversion states
 * and the control byte carrier. Assumes nothing of its surroundings.
 */
package adc_readout_pkg;

    typedef enum logic [1:0] {
        PWR_FULL      = 2'b00,
        PWR_AUTO_DOWN = 2'b01,
        PWR_SHUTDOWN  = 2'b10
    } power_state_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_SAR  = 2'b01,
        CV_PUSH = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic       start;
        logic [2:0] chan;
        logic       spare;
        logic       single_ended;
        logic       power_mode_hi_bit;
        logic       power_mode_lo_bit;
    } ctrl_byte_t;

    typedef struct packed {
        logic [2:0] chan;
        logic       single_ended;
    } mux_cfg_t;

endpackage

// ### logic/word_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-high asynchronous reset.
 */
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,       // system clock
    input  wire logic             rst,       // async reset, active high
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // not full
    input  wire logic [WIDTH-1:0] in_data,   // write word
    output logic                  out_valid, // not empty
    input  wire logic             out_ready, // read accept
    output logic      [WIDTH-1:0] out_data   // oldest word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    wire              push_w = in_valid && in_ready;
    wire              pop_w  = out_valid && out_ready;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk) begin
        if (push_w) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push_w) wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop_w)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
            count_ff <= count_ff + (AW+1)'(push_w) - (AW+1)'(pop_w);
        end
    end

endmodule // word_fifo

// ### bench/host_port.sv
/* Host serial port model: frames control bytes and clocks results out.
   Assumes the converter samples sdi on rising and moves sdo on falling edges. */
`timescale 1ns/1ps
module host_port (
    output logic      sclk,     // serial clock, still outside frames
    output logic      cs_n,     // chip select, active low
    output logic      sdi,      // serial data to converter
    input  wire logic sdo,      // serial data from converter
    input  wire logic sdo_oe_n  // low while sdo is driven
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    // ----------------------------------------
    // framing: zeros ahead of the start bit are hunted over
    // ----------------------------------------
    task automatic send(input logic [9:0] bits);
        #1700 cs_n = 1'b0;
        #60;
        for (int i = 9; i >= 0; i--) begin
            sdi = bits[i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        sdi = 1'b0; // idle low: clocks outside a byte must not look like a start bit
    endtask
    // clock stays low from here until readout
    task automatic read(output logic [15:0] w);
        cs_n = 1'b0;
        #60 sclk = 1'b1;
        #24;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            #24 sclk = 1'b1;
            #23 w[i] = sdo;
            #1;
        end
        sclk = 1'b0;
    endtask
    task automatic deselect;
        cs_n = 1'b1;
    endtask
endmodule // host_port

// ### bench/adc_internal_clock_readout_tb_top.sv
/* Self-checking bench for the converter readout with a host port model.
   Assumes 100 MHz clk, link clock made by host_port at 48 ns. */
`timescale 1ns/1ps
module adc_internal_clock_readout_tb_top;
    import adc_readout_pkg::*;
    logic         clk = 1'b0, rst = 1'b1, power_off_n = 1'b1;
    logic [15:0]  analog_level = 16'h0000, w;
    logic         sclk, cs_n, sdi, busy, sdo, sdo_oe_n;
    power_state_t power_state;
    mux_cfg_t     mux_cfg;
    int           fails = 0, check_count = 0, n;
    logic [15:0]  corner [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
    always #5 clk = ~clk;
    adc_readout DUT (.clk(clk), .rst(rst), .serial_shift_clock(sclk), .cs_n(cs_n), .sdi(sdi),
        .power_off_n(power_off_n), .analog_level(analog_level), .busy(busy), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .power_state(power_state), .mux_cfg(mux_cfg));
    host_port HOST (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    // ----------------------------------------
    // compares and closing
    // ----------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize;
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        n = 0;
        while (busy !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // ----------------------------------------
    // one conversion and two readouts
    // ----------------------------------------
    task automatic convert(input logic [15:0] v, input logic [1:0] pd, input logic drop_cs);
        logic [3:0] cfg;
        cfg = 4'($urandom);
        @(negedge clk) analog_level = v;
        HOST.send({3'b001, cfg[3:1], 1'b0, cfg[0], pd});
        wait_busy(1'b0, 10);
        chk_bit("busy_fall", 1'b0, busy);
        @(negedge clk);
        chk_word("mux_cfg", {12'h000, cfg}, {12'h000, mux_cfg});
        if (drop_cs) HOST.deselect();
        repeat (8) @(negedge clk);
        chk_bit("busy_driven", 1'b0, busy);
        wait_busy(1'b1, 790);
        chk_bit("busy_rise", 1'b1, busy);
        repeat (4) @(negedge clk);
        chk_word("power_state", {14'h0, (pd == 2'b00) ? PWR_AUTO_DOWN : PWR_FULL}, {14'h0, power_state});
        if (drop_cs) chk_bit("sdo_released", 1'b1, sdo_oe_n);
        HOST.read(w);
        chk_word("result", v, w);
        HOST.deselect();
        repeat (6) @(negedge clk);
        chk_bit("sdo_off", 1'b1, sdo_oe_n);
        HOST.read(w);
        chk_word("reread", v, w);
        HOST.deselect();
    endtask
    initial begin
        void'($urandom(32'h1F8F));
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (6) @(negedge clk);
        chk_bit("busy_reset", 1'b1, busy);
        foreach (corner[i]) convert(corner[i], 2'b10, 1'(i));
        repeat (6) convert(16'($urandom), 2'b10, 1'($urandom));
        repeat (2) convert(16'($urandom), 2'b00, 1'($urandom));
        HOST.send({2'b00, 8'h83});
        HOST.deselect();
        repeat (20) @(negedge clk);
        chk_bit("no_conv_ext", 1'b1, busy);
        convert(16'($urandom), 2'b10, 1'b0);
        HOST.send({2'b00, 8'h82});
        wait_busy(1'b0, 10);
        @(negedge clk) power_off_n = 1'b0;
        repeat (6) @(negedge clk);
        chk_word("shutdown", {14'h0, PWR_SHUTDOWN}, {14'h0, power_state});
        chk_bit("busy_abort", 1'b1, busy);
        power_off_n = 1'b1;
        HOST.deselect();
        repeat (6) @(negedge clk);
        convert(16'($urandom), 2'b10, 1'b1);
        summarize();
    end
    initial begin
        #500000;
        fails++;
        summarize();
    end
endmodule // adc_internal_clock_readout_tb_top
